// ===== inc/mhl_consts.vh
// constants for the memory card host link write engine
`ifndef MHL_CONSTS_VH
`define MHL_CONSTS_VH
`define MHL_WIDTH_1 2'h0
`define MHL_WIDTH_4 2'h1
`define MHL_WIDTH_8 2'h2
`define MHL_CMD_BITS 8'h30
`define MHL_RSP_BITS 8'h30
`define MHL_CMD_SEND_CSD 6'h09
`define MHL_CMD_SET_BLKLEN 6'h10
`define MHL_CMD_SELECT 6'h07
`define MHL_CMD_WRITE 6'h18
`define MHL_CRC_STAT_BITS 3'h5
`define MHL_CRC_STAT_OK 3'h2
`define MHL_RSP_TIMEOUT 8'h40
`define MHL_STAT_TIMEOUT 8'h10
`define MHL_BLKLEN_W 12
`endif

// ===== rtl/mhl_buf2.v
// two-entry valid/ready buffer on the write data path
`timescale 1ns/1ps
`default_nettype none
module mhl_buf2 (
  input wire clk, // function clock
  input wire rst, // synchronous reset
  input wire [7:0] in_data, // byte from user
  input wire in_valid, // byte offered
  output wire in_ready, // buffer has room
  output wire [7:0] out_data, // oldest byte
  output wire out_valid, // byte available
  input wire out_ready // consumer takes byte
);
  reg [7:0] mem_r [0:1];
  reg [1:0] cnt_r;
  reg rd_r;
  reg wr_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (push) begin
        mem_r[wr_r] <= in_data;
        wr_r <= ~wr_r;
      end
      if (pop)
        rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // mhl_buf2
`default_nettype wire

// ===== rtl/mhl_write_link.v
// memory card host link: clock divider, command and block write engine
`timescale 1ns/1ps
`include "mhl_consts.vh"
`default_nettype none
module mhl_write_link (
  input wire clk, // function clock, 100 MHz
  input wire rst, // synchronous, active high
  input wire sd_mode, // 1 = sd host, 0 = mmc host
  input wire [1:0] bus_width_sel, // data width select
  input wire [7:0] clock_rate_divisor, // memory clock divisor
  input wire start, // begin write sequence pulse
  input wire [31:0] block_addr, // write command argument
  input wire [`MHL_BLKLEN_W-1:0] card_write_block_length, // bytes
  input wire [7:0] wr_data, // block byte stream
  input wire wr_valid, // byte offered
  output wire wr_ready, // byte accepted
  output reg busy, // sequence active
  output reg done, // sequence finished pulse
  output reg crc_reject, // card rejected block, sticky
  output reg rsp_timeout, // no response, sticky
  output reg card_busy_phase, // card programming
  output reg [119:0] csd_data, // captured csd bits
  output reg card_clock_pin, // memory clock out
  input wire card_cmd_in, // command pin level
  output reg card_cmd_out, // command pin drive value
  output reg card_cmd_oe, // command pin drive enable
  input wire [7:0] card_dat_in, // data pin levels
  output reg [7:0] card_dat_out, // data pin drive values
  output reg [7:0] card_dat_oe // data pin drive enables
);
  localparam S_IDLE = 4'h0, S_CMD = 4'h1, S_RWAIT = 4'h2, S_RSP = 4'h3;
  localparam S_NEXT = 4'h4, S_DSTART = 4'h5, S_DATA = 4'h6, S_CRC = 4'h7;
  localparam S_DEND = 4'h8, S_SWAIT = 4'h9, S_STAT = 4'hA, S_BUSY = 4'hB;
  localparam P_CSD = 2'h0, P_BLK = 2'h1, P_SEL = 2'h2, P_WR = 2'h3;
  // crc7 step for the command token
  function [6:0] crc7;
    input [6:0] c;
    input b;
    reg f;
    begin
      f = c[6] ^ b;
      crc7 = {c[5:3], c[2] ^ f, c[1:0], f};
    end
  endfunction
  // crc16 step per data line
  function [15:0] crc16;
    input [15:0] c;
    input b;
    reg f;
    begin
      f = c[15] ^ b;
      crc16 = {c[14:12], c[11] ^ f, c[10:5], c[4] ^ f, c[3:0], f};
    end
  endfunction
  reg s1_cmd_r, s2_cmd_r;
  reg [7:0] s1_dat_r, s2_dat_r;
  reg [7:0] div_cnt_r;
  // >= so a smaller divisor takes effect without a counter wrap
  wire tick_hit = (div_cnt_r >= clock_rate_divisor);
  wire tick_fall = tick_hit && card_clock_pin;
  wire tick_rise = tick_hit && !card_clock_pin;
  reg [3:0] st_r;
  reg [1:0] phase_r;
  reg [47:0] sh_r;
  reg [7:0] bit_r;
  reg [6:0] c7_r;
  reg [135:0] rsp_r;
  reg [`MHL_BLKLEN_W-1:0] byte_r;
  reg [7:0] cur_r;
  reg [2:0] sub_r;
  reg [4:0] cbit_r;
  reg [15:0] c16_r [0:7];
  reg [2:0] stat_r;
  wire [7:0] buf_data;
  wire buf_valid;
  reg buf_take;
  wire cmd_s = s2_cmd_r;
  wire dat0_s = s2_dat_r[0];
  // taken from the fresh response, not the csd copy still being loaded
  wire [`MHL_BLKLEN_W-1:0] req_len = (`MHL_BLKLEN_W'h1 << rsp_r[83:80]);
  wire [2:0] bits_per;
  integer k;
  assign bits_per = (bus_width_sel == `MHL_WIDTH_8 && !sd_mode) ? 3'h0 :
    (bus_width_sel == `MHL_WIDTH_4) || (bus_width_sel == `MHL_WIDTH_8) ?
    3'h1 : 3'h7;
  mhl_buf2 u_buf (
    .clk(clk),
    .rst(rst),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_take)
  );
  // pins pass two flops; second stage only is read
  always @(posedge clk) begin
    s1_cmd_r <= card_cmd_in;
    s2_cmd_r <= s1_cmd_r;
    s1_dat_r <= card_dat_in;
    s2_dat_r <= s1_dat_r;
  end
  // ticks share the pin's edge, so drive lands as the clock falls
  always @(posedge clk) begin
    if (rst) begin
      div_cnt_r <= 8'h00;
      card_clock_pin <= 1'b0;
    end else if (tick_hit) begin
      div_cnt_r <= 8'h00;
      card_clock_pin <= ~card_clock_pin;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  always @(posedge clk) begin
    buf_take <= 1'b0;
    done <= 1'b0;
    if (rst) begin
      st_r <= S_IDLE;
      phase_r <= P_CSD;
      busy <= 1'b0;
      crc_reject <= 1'b0;
      rsp_timeout <= 1'b0;
      card_busy_phase <= 1'b0;
      csd_data <= 120'h0;
      card_cmd_out <= 1'b1;
      card_cmd_oe <= 1'b0;
      card_dat_out <= 8'hFF;
      card_dat_oe <= 8'h00;
      sh_r <= 48'h0;
      bit_r <= 8'h00;
      c7_r <= 7'h00;
      rsp_r <= 136'h0;
      byte_r <= {`MHL_BLKLEN_W{1'b0}};
      cur_r <= 8'h00;
      sub_r <= 3'h0;
      cbit_r <= 5'h00;
      stat_r <= 3'h0;
    end else begin
      case (st_r)
        S_IDLE: begin
          card_cmd_oe <= 1'b0;
          card_dat_oe <= 8'h00;
          if (start) begin
            busy <= 1'b1;
            crc_reject <= 1'b0;
            rsp_timeout <= 1'b0;
            phase_r <= P_CSD;
            sh_r <= {2'b01, `MHL_CMD_SEND_CSD, 32'h0, 8'h01};
            st_r <= S_CMD;
            bit_r <= 8'h00;
            c7_r <= 7'h00;
          end
        end
        S_CMD: if (tick_fall) begin
          card_cmd_oe <= 1'b1;
          if (bit_r < 8'h28) begin
            card_cmd_out <= sh_r[47];
            c7_r <= crc7(c7_r, sh_r[47]);
          end else if (bit_r < 8'h2F) begin
            card_cmd_out <= c7_r[6];
            c7_r <= {c7_r[5:0], 1'b0};
          end else begin
            card_cmd_out <= 1'b1;
          end
          sh_r <= {sh_r[46:0], 1'b0};
          bit_r <= bit_r + 8'h01;
          if (bit_r == `MHL_CMD_BITS) begin
            card_cmd_oe <= 1'b0;
            bit_r <= 8'h00;
            st_r <= S_RWAIT;
          end
        end
        S_RWAIT: if (tick_rise) begin
          bit_r <= bit_r + 8'h01;
          if (!cmd_s) begin
            rsp_r <= 136'h0;
            bit_r <= 8'h01;
            st_r <= S_RSP;
          end else if (bit_r == `MHL_RSP_TIMEOUT) begin
            rsp_timeout <= 1'b1;
            st_r <= S_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        S_RSP: if (tick_rise) begin
          rsp_r <= {rsp_r[134:0], cmd_s};
          bit_r <= bit_r + 8'h01;
          if (bit_r == ((phase_r == P_CSD) ? 8'h87 : 8'h2F))
            st_r <= S_NEXT;
        end
        S_NEXT: begin
          bit_r <= 8'h00;
          c7_r <= 7'h00;
          st_r <= S_CMD;
          case (phase_r)
            P_CSD: begin
              csd_data <= rsp_r[119:0];
              if (req_len != card_write_block_length) begin
                phase_r <= P_BLK;
                sh_r <= {2'b01, `MHL_CMD_SET_BLKLEN,
                  {(32-`MHL_BLKLEN_W){1'b0}}, card_write_block_length, 8'h01};
              end else begin
                phase_r <= P_SEL;
                sh_r <= {2'b01, `MHL_CMD_SELECT, 32'h0, 8'h01};
              end
            end
            P_BLK: begin
              phase_r <= P_SEL;
              sh_r <= {2'b01, `MHL_CMD_SELECT, 32'h0, 8'h01};
            end
            P_SEL: begin
              phase_r <= P_WR;
              sh_r <= {2'b01, `MHL_CMD_WRITE, block_addr, 8'h01};
            end
            default: begin
              byte_r <= {`MHL_BLKLEN_W{1'b0}};
              st_r <= S_DSTART;
            end
          endcase
        end
        S_DSTART: if (tick_fall && buf_valid) begin
          for (k = 0; k < 8; k = k + 1)
            c16_r[k] <= 16'h0;
          card_dat_oe <= (bits_per == 3'h0) ? 8'hFF :
            (bits_per == 3'h1) ? 8'h0F : 8'h01;
          card_dat_out <= 8'h00;
          cur_r <= buf_data;
          buf_take <= 1'b1;
          sub_r <= 3'h0;
          st_r <= S_DATA;
        end
        S_DATA: if (tick_fall) begin
          if (bits_per == 3'h0) begin
            card_dat_out <= cur_r;
            for (k = 0; k < 8; k = k + 1)
              c16_r[k] <= crc16(c16_r[k], cur_r[k]);
          end else if (bits_per == 3'h1) begin
            card_dat_out <= {4'hF, cur_r[7:4]};
            for (k = 0; k < 4; k = k + 1)
              c16_r[k] <= crc16(c16_r[k], cur_r[k+4]);
            cur_r <= {cur_r[3:0], 4'h0};
          end else begin
            card_dat_out <= {7'h7F, cur_r[7]};
            c16_r[0] <= crc16(c16_r[0], cur_r[7]);
            cur_r <= {cur_r[6:0], 1'b0};
          end
          sub_r <= sub_r + 3'h1;
          if (sub_r == bits_per) begin
            sub_r <= 3'h0;
            byte_r <= byte_r + 1'b1;
            if (byte_r + 1'b1 == card_write_block_length) begin
              cbit_r <= 5'h00;
              st_r <= S_CRC;
            end else begin
              cur_r <= buf_data; // stall-free: buffer holds next byte
              buf_take <= 1'b1;
            end
          end
        end
        S_CRC: if (tick_fall) begin
          for (k = 0; k < 8; k = k + 1) begin
            card_dat_out[k] <= c16_r[k][15];
            c16_r[k] <= {c16_r[k][14:0], 1'b0};
          end
          cbit_r <= cbit_r + 5'h01;
          if (cbit_r == 5'h0F)
            st_r <= S_DEND;
        end
        S_DEND: if (tick_fall) begin
          card_dat_out <= 8'hFF;
          cbit_r <= 5'h11;
          // end bit stands one full card clock before release
          if (cbit_r == 5'h11) begin
            card_dat_oe <= 8'h00;
            bit_r <= 8'h00;
            st_r <= S_SWAIT;
          end
        end
        S_SWAIT: if (tick_rise) begin
          bit_r <= bit_r + 8'h01;
          if (!dat0_s) begin
            bit_r <= 8'h00;
            st_r <= S_STAT;
          end else if (bit_r == `MHL_STAT_TIMEOUT) begin
            rsp_timeout <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_STAT: if (tick_rise) begin
          stat_r <= {stat_r[1:0], dat0_s};
          bit_r <= bit_r + 8'h01;
          if (bit_r == {5'h00, `MHL_CRC_STAT_BITS} - 8'h03) begin
            crc_reject <= ({stat_r[1:0], dat0_s} != `MHL_CRC_STAT_OK);
            st_r <= S_BUSY;
            bit_r <= 8'h00;
          end
        end
        S_BUSY: if (tick_rise) begin
          bit_r <= 8'h01;
          card_busy_phase <= !dat0_s;
          if (dat0_s && bit_r != 8'h00) begin
            card_busy_phase <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule // mhl_write_link
`default_nettype wire

// ===== testbench/mhl_write_link_props.sv
// port assertions for the card link write engine
`timescale 1ns/1ps
`include "mhl_consts.vh"
`default_nettype none
module mhl_write_link_props (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic sd_mode, // sd host
  input wire logic [1:0] bus_width_sel, // width
  input wire logic [7:0] clock_rate_divisor, // divisor
  input wire logic start, // start
  input wire logic busy, // active
  input wire logic done, // finish
  input wire logic crc_reject, // reject
  input wire logic card_busy_phase, // card busy
  input wire logic card_clock_pin, // card clock
  input wire logic card_cmd_oe, // cmd enable
  input wire logic [7:0] card_dat_in, // data levels
  input wire logic [7:0] card_dat_oe // data enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic pin_r;
  logic seen_r;
  logic [8:0] cnt_r;
  // first toggle of a sequence only arms the half period check
  always @(posedge clk) begin
    pin_r <= card_clock_pin;
    if (rst || !busy) seen_r <= 1'b0;
    else if (pin_r != card_clock_pin) seen_r <= 1'b1;
    if (rst || pin_r != card_clock_pin) cnt_r <= 9'h000;
    else cnt_r <= cnt_r + 9'h001;
  end
  property p_idle_quiet;
    !busy |-> !card_cmd_oe && card_dat_oe == 8'h00;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pins driven idle");
  property p_one_line;
    bus_width_sel == `MHL_WIDTH_1 |-> card_dat_oe[7:1] == 7'h00;
  endproperty
  a_one_line: assert property (p_one_line) else $error("extra lines 1bit");
  property p_four_line;
    sd_mode || bus_width_sel != `MHL_WIDTH_8 |-> card_dat_oe[7:4] == 4'h0;
  endproperty
  a_four_line: assert property (p_four_line) else $error("upper lines used");
  property p_clk_div;
    busy && seen_r && pin_r != card_clock_pin
      |-> cnt_r == {1'b0, clock_rate_divisor};
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("bad half period");
  property p_start_busy;
    start && !busy |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start lost");
  property p_done_once;
    done |=> !done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done too long");
  property p_no_drive_busy;
    card_busy_phase |-> !card_dat_oe[0];
  endproperty
  a_no_drive_busy: assert property (p_no_drive_busy) else $error("drove busy");
  property p_busy_end;
    card_busy_phase && card_dat_in[0] [*8] |-> ##[0:16] !card_busy_phase;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
  property p_reject_sticky;
    crc_reject && !(start && !busy) |=> crc_reject;
  endproperty
  a_reject_sticky: assert property (p_reject_sticky) else $error("flag lost");
  c_reject: cover property ($rose(crc_reject));
  c_busy: cover property ($fell(card_busy_phase));
  c_wide: cover property (done && bus_width_sel == `MHL_WIDTH_8);
endmodule // mhl_write_link_props
bind mhl_write_link mhl_write_link_props u_props (.clk, .rst, .sd_mode,
  .bus_width_sel, .clock_rate_divisor, .start, .busy, .done, .crc_reject,
  .card_busy_phase, .card_clock_pin, .card_cmd_oe, .card_dat_in,
  .card_dat_oe);
`default_nettype wire

// ===== testbench/mhl_card_model.sv
// behavioural memory card on the far side of the link
`timescale 1ns/1ps
`include "mhl_consts.vh"
`default_nettype none
module mhl_card_model (
  input wire logic sclk, // card clock
  input wire logic cmd_w, // command line
  input wire logic [7:0] dat_w, // data lines
  input wire logic [3:0] lines, // active lines
  input wire logic [11:0] blk_len, // block bytes
  input wire logic reject, // crc error
  input wire logic mute, // no answer
  output logic cmd_en, // drive cmd
  output logic cmd_val, // cmd value
  output logic dat_en, // drive data0
  output logic dat_val, // data0 value
  output logic [15:0] ev_n, // event count
  output logic [7:0] ev_b // event value
);
  logic [135:0] sh;
  task automatic drive(input logic on_dat, input int n);
    int i;
    repeat (2) @(posedge sclk);
    for (i = 135; i > 135 - n; i--) begin
      @(negedge sclk);
      if (on_dat) dat_val = sh[i];
      else cmd_val = sh[i];
      dat_en = on_dat;
      cmd_en = !on_dat;
    end
    @(negedge sclk);
    cmd_en = 1'b0; // released lines float to pull-up
    dat_en = 1'b0;
  endtask
  initial begin : run
    logic [47:0] c;
    logic [7:0] acc;
    logic [7:0] m;
    int i;
    cmd_en = 1'b0;
    cmd_val = 1'b1;
    dat_en = 1'b0;
    dat_val = 1'b1;
    ev_n = 16'h0000;
    ev_b = 8'h00;
    forever begin
      @(posedge sclk);
      if (cmd_w === 1'b0) begin
        for (i = 0; i < 47; i++) begin
          @(posedge sclk);
          c = {c[46:0], cmd_w};
        end
        ev_b = {2'b00, c[45:40]};
        ev_n++;
        if (!mute) begin
          if (c[45:40] == `MHL_CMD_SEND_CSD) begin
            sh = {2'b00, 6'h3F, 128'h1};
            sh[83:80] = 4'h9;
            drive(1'b0, 136);
          end else begin
            sh[135:88] = {2'b00, c[45:40], 32'h0, 7'h00, 1'b1};
            drive(1'b0, 48);
          end
          if (c[45:40] == `MHL_CMD_WRITE) begin
            m = 8'hFF >> (8 - lines);
            do @(posedge sclk); while (dat_w[0] !== 1'b0);
            acc = 8'h00;
            for (i = 0; i < blk_len * 32'd8 / lines; i++) begin
              @(posedge sclk);
              acc = (acc << lines) | (dat_w & m);
              if ((i + 1) % (8 / lines) == 0) begin
                ev_b = acc;
                ev_n++;
              end
            end
            repeat (17) @(posedge sclk);
            ev_b = dat_w & m;
            ev_n++;
            sh[135:111] = {1'b0, reject ? 3'h5 : `MHL_CRC_STAT_OK, 1'b1,
                           20'h00000};
            drive(1'b1, 25);
          end
        end
      end
    end
  end
endmodule // mhl_card_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the card link write engine
`timescale 1ns/1ps
`include "mhl_consts.vh"
`default_nettype none
module tb_top;
  logic clk, rst, sd_mode, start, wr_valid, wr_ready, busy, done;
  logic crc_reject, rsp_timeout, card_busy_phase, card_clock_pin;
  logic card_cmd_out, card_cmd_oe, m_rej, m_mute;
  logic cmd_en, cmd_val, dat_en, dat_val;
  logic [1:0] bus_width_sel;
  logic [3:0] m_lines;
  logic [7:0] clock_rate_divisor, wr_data, card_dat_out, card_dat_oe, ev_b;
  logic [11:0] card_write_block_length;
  logic [15:0] ev_n;
  logic [31:0] block_addr;
  logic [119:0] csd_data;
  logic [7:0] exp_q[$];
  logic [7:0] dq[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  wire cmd_w = card_cmd_oe ? card_cmd_out : (cmd_en ? cmd_val : 1'b1);
  wire [7:0] dat_w = (card_dat_oe & card_dat_out) |
    (~card_dat_oe & {7'h7F, dat_en ? dat_val : 1'b1});
  mhl_write_link u_dut (.clk, .rst, .sd_mode, .bus_width_sel,
    .clock_rate_divisor, .start, .block_addr, .card_write_block_length,
    .wr_data, .wr_valid, .wr_ready, .busy, .done, .crc_reject, .rsp_timeout,
    .card_busy_phase, .csd_data, .card_clock_pin, .card_cmd_in(cmd_w),
    .card_cmd_out, .card_cmd_oe, .card_dat_in(dat_w), .card_dat_out,
    .card_dat_oe);
  mhl_card_model u_card (.sclk(card_clock_pin), .cmd_w, .dat_w,
    .lines(m_lines), .blk_len(card_write_block_length), .reject(m_rej),
    .mute(m_mute), .cmd_en, .cmd_val, .dat_en, .dat_val, .ev_n, .ev_b);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test;
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  always @(ev_n) begin
    if (ev_n != 16'h0000) begin
      if (exp_q.size() > 0) chk(ev_b, exp_q.pop_front());
      else chk(ev_b, ~ev_b);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      stop_test;
    end
  end
  task automatic run(input logic s, input logic [1:0] ws,
      input logic [7:0] dv, input logic [11:0] len, input logic [3:0] ln,
      input logic rj, input logic mt);
    int i, t;
    logic seen, bp;
    sd_mode = s;
    bus_width_sel = ws;
    clock_rate_divisor = dv;
    card_write_block_length = len;
    m_lines = ln;
    m_rej = rj;
    m_mute = mt;
    block_addr = $urandom;
    exp_q.push_back({2'b00, `MHL_CMD_SEND_CSD});
    if (!mt) begin
      if (len != 12'h200) exp_q.push_back({2'b00, `MHL_CMD_SET_BLKLEN});
      exp_q.push_back({2'b00, `MHL_CMD_SELECT});
      exp_q.push_back({2'b00, `MHL_CMD_WRITE});
      for (i = 0; i < len; i++) begin
        dq.push_back(8'($urandom));
        exp_q.push_back(dq[i]);
      end
      exp_q.push_back(8'hFF >> (8 - ln));
    end
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    @(posedge clk);
    #1 start = 1'b1; // refused while busy
    @(posedge clk);
    #1 start = 1'b0;
    seen = 1'b0;
    bp = 1'b0;
    for (t = 0; t < 30000 && !seen; t++) begin
      wr_valid = dq.size() > 0;
      wr_data = wr_valid ? dq[0] : 8'h00;
      @(posedge clk);
      if (done) seen = 1'b1;
      if (card_busy_phase) bp = 1'b1;
      if (wr_valid && wr_ready) void'(dq.pop_front());
      #1;
    end
    wr_valid = 1'b0;
    dq.delete();
    chk({6'h00, crc_reject, rsp_timeout}, {6'h00, rj, mt});
    chk({5'h00, seen, bp, busy}, {5'h00, 1'b1, !mt, 1'b0});
    chk(8'(exp_q.size()), 8'h00);
    chk({csd_data[83:80], csd_data[3:0]}, 8'h91);
    exp_q.delete();
  endtask
  initial begin
    void'($urandom(32'hB1D4));
    rst = 1'b1;
    start = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    sd_mode = 1'b0;
    bus_width_sel = `MHL_WIDTH_1;
    clock_rate_divisor = 8'h00;
    block_addr = 32'h0;
    card_write_block_length = 12'h200;
    m_lines = 4'h1;
    m_rej = 1'b0;
    m_mute = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    run(1'b0, `MHL_WIDTH_1, 8'h00, 12'h010, 4'h1, 1'b0, 1'b0);
    run(1'b1, `MHL_WIDTH_4, 8'h01, 12'h200, 4'h4, 1'b0, 1'b0);
    run(1'b0, `MHL_WIDTH_8, 8'h02, 12'h040, 4'h8, 1'b1, 1'b0);
    run(1'b1, `MHL_WIDTH_8, 8'h00, 12'h020, 4'h4, 1'b0, 1'b0);
    run(1'b0, `MHL_WIDTH_1, 8'h01, 12'h010, 4'h1, 1'b0, 1'b1);
    run(1'b0, `MHL_WIDTH_4, 8'h00, 12'h010, 4'h4, 1'b0, 1'b0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
